/* File: src/tzm_consts.svh */
`ifndef TZM_CONSTS_SVH
`define TZM_CONSTS_SVH

// core clock
`define TZM_CLK_PERIOD_NS 25
// sense current repetition: 1 kHz at 50 % duty
`define TZM_PULSE_RATE_HZ 1000
`define TZM_DUTY_PERCENT 50
`define TZM_PULSE_PERIOD_NS (1000000000 / `TZM_PULSE_RATE_HZ)
`define TZM_ON_TIME_NS ((`TZM_PULSE_PERIOD_NS * `TZM_DUTY_PERCENT) / 100)
// longest-time rounding: floor
`define TZM_ON_CYCLES (`TZM_ON_TIME_NS / `TZM_CLK_PERIOD_NS)

// converter result width, millivolts
`define TZM_MV_W 12
// pin voltage thresholds, millivolts
`define TZM_MV_T8 12'd880
`define TZM_MV_T7 12'd920
`define TZM_MV_T6 12'd960
`define TZM_MV_T5 12'd1000
`define TZM_MV_T4 12'd1040
`define TZM_MV_T3 12'd1080
`define TZM_MV_T2 12'd1120
`define TZM_MV_T1 12'd1200

// thermal zone code bits and reset
`define TZM_CODE_RESET 8'h00
`define TZM_BIT_THROTTLE 7
`define TZM_BIT_ALERT_SET 6
`define TZM_BIT_ALERT_CLR 5
// first status register
`define TZM_STATUS_RESET 8'h00
`define TZM_STATUS_THERMAL 1

`endif

/* File: src/tzm_pkg.sv */
package tzm_pkg;

  // host-facing flags, both active low
  typedef struct packed {
    logic alert_n;
    logic throttle_n;
  } tzm_flags_t;

  // qualifying transitions of the zone code
  typedef struct packed {
    logic rise6;
    logic fall5;
    logic rise7;
    logic fall6;
  } tzm_edges_t;

  // sense pulse phase
  typedef enum logic [0:0] {
    TZM_PH_OFF = 1'b0,
    TZM_PH_ON = 1'b1
  } tzm_phase_t;

endpackage

/* File: src/tzm_monitor.sv */
`timescale 1ns/1ps
`include "tzm_consts.svh"

// What this block does
// - pulse sense current, 1 kHz, equal halves
// - convert pin voltage, hold readable zone code
// - thermometer code from pin voltage table
// - bit 6 rising sets status bit 1
// - status change asserts attention low
// - status read releases attention
// - bit 7 rising asserts throttle low
// - throttle released when bit 6 falls
// - bit 5 falling clears status, re-alerts
module tzm_monitor #(
  parameter int unsigned ON_CYCLES = `TZM_ON_CYCLES
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // converter result, foreign domain
  input wire logic conv_clk_i,
  input wire logic [`TZM_MV_W-1:0] thermistor_pin_voltage_i,
  // host status read
  input wire logic status_read_i,
  // sense current drive
  output logic sense_current_en_o,
  // registers
  output logic [7:0] thermal_zone_code_o,
  output logic [7:0] status_1_o,
  // host flags
  output tzm_pkg::tzm_flags_t flags_o
);
  import tzm_pkg::*;

  localparam int unsigned CNT_W = $clog2(ON_CYCLES + 1);
  localparam int unsigned SYN_W = `TZM_MV_W + 1;

  // voltage to thermometer code
  function automatic logic [7:0] tzm_encode(input logic [`TZM_MV_W-1:0] mv);
    logic [7:0] c;
    c = 8'h00;
    if (mv <= `TZM_MV_T8) begin
      c = 8'hff;
    end else if (mv <= `TZM_MV_T7) begin
      c = 8'h7f;
    end else if (mv <= `TZM_MV_T6) begin
      c = 8'h3f;
    end else if (mv <= `TZM_MV_T5) begin
      c = 8'h1f;
    end else if (mv <= `TZM_MV_T4) begin
      c = 8'h0f;
    end else if (mv <= `TZM_MV_T3) begin
      c = 8'h07;
    end else if (mv <= `TZM_MV_T2) begin
      c = 8'h03;
    end else if (mv <= `TZM_MV_T1) begin
      c = 8'h01;
    end
    return c;
  endfunction

  // two-flop synchronisers
  logic [SYN_W-1:0] sync1_q;
  logic [SYN_W-1:0] sync2_q;
  logic [SYN_W-1:0] sync_in;

  assign sync_in = {conv_clk_i, thermistor_pin_voltage_i};

  genvar gi;
  generate
    for (gi = 0; gi < SYN_W; gi++) begin : g_sync
      always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
        end else begin
          sync1_q[gi] <= sync_in[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  // converter clock edge detect
  logic conv_clk_prev_q;
  logic conv_edge;

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      conv_clk_prev_q <= 1'b0;
    end else begin
      conv_clk_prev_q <= sync2_q[SYN_W-1];
    end
  end

  assign conv_edge = sync2_q[SYN_W-1] & ~conv_clk_prev_q;

  // converter result capture
  logic [`TZM_MV_W-1:0] conv_mv_q;

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      conv_mv_q <= '0;
    end else if (conv_edge) begin
      conv_mv_q <= sync2_q[`TZM_MV_W-1:0];
    end
  end

  // sense current pulse generator
  logic [CNT_W-1:0] cnt_q;
  tzm_phase_t phase_q;
  logic half_done;
  logic period_tick;

  assign half_done = (cnt_q == CNT_W'(ON_CYCLES - 1));
  assign period_tick = half_done && (phase_q == TZM_PH_ON);

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_q <= '0;
    end else if (half_done) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      phase_q <= TZM_PH_OFF;
    end else if (half_done) begin
      case (phase_q)
        TZM_PH_OFF: begin
          phase_q <= TZM_PH_ON;
        end
        TZM_PH_ON: begin
          phase_q <= TZM_PH_OFF;
        end
        default: begin
          phase_q <= TZM_PH_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sense_current_en_o <= 1'b0;
    end else begin
      sense_current_en_o <= (phase_q == TZM_PH_ON);
    end
  end

  // zone code, sampled at end of each on phase
  logic [7:0] code_q;
  logic [7:0] code_prev_q;
  logic code_upd_q;

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      code_q <= `TZM_CODE_RESET;
      code_prev_q <= `TZM_CODE_RESET;
      code_upd_q <= 1'b0;
    end else begin
      code_upd_q <= period_tick;
      if (period_tick) begin
        code_prev_q <= code_q;
        code_q <= tzm_encode(conv_mv_q);
      end
    end
  end

  assign thermal_zone_code_o = code_q;

  // transition detection, one cycle after each update
  tzm_edges_t edges;

  always_comb begin
    edges = '0;
    if (code_upd_q) begin
      edges.rise6 = code_q[`TZM_BIT_ALERT_SET] & ~code_prev_q[`TZM_BIT_ALERT_SET];
      edges.fall5 = ~code_q[`TZM_BIT_ALERT_CLR] & code_prev_q[`TZM_BIT_ALERT_CLR];
      edges.rise7 = code_q[`TZM_BIT_THROTTLE] & ~code_prev_q[`TZM_BIT_THROTTLE];
      edges.fall6 = ~code_q[`TZM_BIT_ALERT_SET] & code_prev_q[`TZM_BIT_ALERT_SET];
    end
  end

  // first status register
  logic [7:0] status_q;

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      status_q <= `TZM_STATUS_RESET;
    end else if (edges.rise6) begin
      status_q[`TZM_STATUS_THERMAL] <= 1'b1;
    end else if (edges.fall5) begin
      status_q[`TZM_STATUS_THERMAL] <= 1'b0;
    end
  end

  assign status_1_o = status_q;

  // attention and throttle flags
  tzm_flags_t flags_q;

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flags_q.alert_n <= 1'b1;
    end else if (edges.rise6 || edges.fall5) begin
      flags_q.alert_n <= 1'b0;
    end else if (status_read_i) begin
      flags_q.alert_n <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flags_q.throttle_n <= 1'b1;
    end else if (edges.rise7) begin
      flags_q.throttle_n <= 1'b0;
    end else if (edges.fall6) begin
      flags_q.throttle_n <= 1'b1;
    end
  end

  assign flags_o = flags_q;

endmodule

/* File: tb/tzm_monitor_chk.sv */
`timescale 1ns/1ps
module tzm_monitor_chk #(
  parameter int unsigned ON_CYCLES = 20
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // inputs
  input wire logic conv_clk_i,
  input wire logic [11:0] thermistor_pin_voltage_i,
  input wire logic status_read_i,
  // outputs
  input wire logic sense_current_en_o,
  input wire logic [7:0] thermal_zone_code_o,
  input wire logic [7:0] status_1_o,
  input wire tzm_pkg::tzm_flags_t flags_o
);
  import tzm_pkg::*;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  // cycles since the last change of the sense drive
  logic en_prev_q;
  logic en_seen_q;
  int unsigned en_run_q;
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      en_prev_q <= 1'b0;
      en_seen_q <= 1'b0;
      en_run_q <= 0;
    end else begin
      en_prev_q <= sense_current_en_o;
      if (sense_current_en_o != en_prev_q) begin
        en_seen_q <= 1'b1;
        en_run_q <= 0;
      end else begin
        en_run_q <= en_run_q + 1;
      end
    end
  end
  sequence s_set;
    ##1 (status_1_o[1] && !flags_o.alert_n);
  endsequence
  sequence s_clr;
    ##1 (!status_1_o[1] && !flags_o.alert_n);
  endsequence
  property p_pulse;
    (sense_current_en_o != en_prev_q) && en_seen_q |-> en_run_q == ON_CYCLES - 1;
  endproperty
  property p_sample;
    $changed(thermal_zone_code_o) |-> sense_current_en_o ##1 !sense_current_en_o;
  endproperty
  property p_set;
    $rose(thermal_zone_code_o[6]) |-> s_set;
  endproperty
  property p_clr;
    $fell(thermal_zone_code_o[5]) |-> s_clr;
  endproperty
  property p_thr;
    $rose(thermal_zone_code_o[7]) |=> !flags_o.throttle_n;
  endproperty
  property p_rel;
    $fell(thermal_zone_code_o[6]) |=> flags_o.throttle_n;
  endproperty
  property p_read;
    status_read_i && $stable(thermal_zone_code_o) |=> flags_o.alert_n;
  endproperty
  property p_quiet;
    $fell(flags_o.alert_n) |-> $past(thermal_zone_code_o) != $past(thermal_zone_code_o, 2);
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse");
  a_sample: assert property (p_sample) else $error("sample");
  a_set: assert property (p_set) else $error("set");
  a_clr: assert property (p_clr) else $error("clear");
  a_thr: assert property (p_thr) else $error("throttle");
  a_rel: assert property (p_rel) else $error("release");
  a_read: assert property (p_read) else $error("read");
  a_quiet: assert property (p_quiet) else $error("quiet");
endmodule
bind tzm_monitor tzm_monitor_chk #(.ON_CYCLES(ON_CYCLES)) tzm_monitor_chk_inst (
  .core_clk_i(core_clk_i), .nrst_i(nrst_i), .conv_clk_i(conv_clk_i),
  .thermistor_pin_voltage_i(thermistor_pin_voltage_i), .status_read_i(status_read_i),
  .sense_current_en_o(sense_current_en_o), .thermal_zone_code_o(thermal_zone_code_o),
  .status_1_o(status_1_o), .flags_o(flags_o));

/* File: tb/tzm_conv_model.sv */
`timescale 1ns/1ps
module tzm_conv_model (
  // converter side
  output logic conv_clk_o,
  output logic [11:0] mv_o,
  // requested voltage
  input wire logic [11:0] mv_i
);
  initial begin
    conv_clk_o = 1'b0;
    mv_o = 12'h000;
    #37;
    forever #100 conv_clk_o = ~conv_clk_o;
  end
  // new word only while strobe low
  always @(negedge conv_clk_o) mv_o <= mv_i;
endmodule

/* File: tb/tzm_monitor_tb.sv */
`timescale 1ns/1ps
module tzm_monitor_tb;
  import tzm_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, rd = 1'b0, cclk, en, est = 1'b0, eth = 1'b1, r6, f5;
  logic [11:0] mv_set = 12'h514, mv;
  logic [7:0] code, st, pc = 8'h00, ec;
  tzm_flags_t fl;
  int num_errors = 0, compares = 0, seed = 32'h2052, v;
  time t0 = 0;
  int tab[$] = '{12'h514, 12'h44c, 12'h3e8, 12'h3c0, 12'h3ac, 12'h370,
    12'h384, 12'h3a2, 12'h3f2, 12'h514};
  always #12.5 clk = ~clk;
  tzm_conv_model tzm_conv_model_inst (.conv_clk_o(cclk), .mv_o(mv), .mv_i(mv_set));
  tzm_monitor #(.ON_CYCLES(20)) tzm_monitor_inst (.core_clk_i(clk), .nrst_i(nrst),
    .conv_clk_i(cclk), .thermistor_pin_voltage_i(mv), .status_read_i(rd),
    .sense_current_en_o(en), .thermal_zone_code_o(code), .status_1_o(st), .flags_o(fl));
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic print_verdict;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // model of the zone code
  function automatic logic [7:0] enc(int m);
    if (m <= 12'h370) return 8'hff;
    if (m > 12'h4b0) return 8'h00;
    if (m > 12'h460) return 8'h01;
    return 8'hff >> ((m - 12'h371) / 12'h28 + 1);
  endfunction
  initial begin
    #100000;
    num_errors++;
    print_verdict();
  end
  initial begin
    repeat (6) @(posedge clk);
    #2 nrst = 1'b1;
    for (int i = 0; i < 30; i++) begin
      @(negedge en);
      if (i > 0) chk("period", 8'h28, 8'(($time - t0) / 25));
      t0 = $time;
      @(posedge clk);
      #2 ec = enc(mv_set);
      r6 = ec[6] & ~pc[6];
      f5 = ~ec[5] & pc[5];
      if (r6) est = 1'b1;
      else if (f5) est = 1'b0;
      if (ec[7] & ~pc[7]) eth = 1'b0;
      if (~ec[6] & pc[6]) eth = 1'b1;
      pc = ec;
      chk("code", ec, code);
      chk("status", {6'h00, est, 1'b0}, st);
      chk("throttle", {7'h00, eth}, {7'h00, fl.throttle_n});
      chk("alert", {7'h00, ~(r6 | f5)}, {7'h00, fl.alert_n});
      v = i < 9 ? tab[i + 1] : 12'h348 + $unsigned($random(seed)) % 12'h1a4;
      mv_set = v[11:0];
      rd = 1'b1;
      @(posedge clk);
      #2 rd = 1'b0;
      @(posedge clk);
      #2 chk("release", 8'h01, {7'h00, fl.alert_n});
    end
    print_verdict();
  end
endmodule
